//--- src/fgrt_pkg.sv
// Package for the fine-grain read trap block: field positions, offsets,
// reset values and register map.
// Assumes an AXI4-Lite master and a core that presents one read request.
// Behaviour
// - Divert needs hypervisor on, monitor absent or enabling; class 0x18
// - A field at zero never diverts reads of its registers
// - All trap fields clear to zero on warm reset
// - Five limited-order fields exist only with that feature, else zero
// - Two instruction key fields exist only with pointer auth, else zero
// - Bit 24 diverts kernel reads of memory attribute indirection
// - Bit 23 diverts kernel reads of limited-order start register
// - Bit 22 diverts kernel reads of limited-order number register
// - Bit 21 diverts kernel reads of limited-order ident register
// - Bit 20 diverts kernel reads of limited-order end register
// - Bit 19 diverts kernel reads of limited-order control register
// - Bit 18 diverts kernel reads of interrupt status register
// - Bit 17 diverts kernel reads of fault address register
// - Bit 16 diverts kernel reads of exception syndrome register
// - Bit 15 diverts kernel and user zero-block ident unless host pair
// - Bit 14 diverts kernel and user cache type reads unless host pair
// - Bit 13 diverts kernel reads of cache size select register
// - Bit 12 diverts kernel reads of coprocessor access control
// - Bit 11 diverts kernel reads of context ident register
// - Bits 10 and 9 divert cache level and cache size ident reads
// - Bit 8 diverts kernel reads of either instruction key B half
// - Bit 7 diverts kernel reads of either instruction key A half
package fgrt_pkg;
	localparam logic [3:0] FGRT_OFS_CTRL = 4'h0;
	localparam logic [3:0] FGRT_OFS_CFG = 4'h4;
	localparam logic [3:0] FGRT_OFS_STAT = 4'h8;
	localparam logic [3:0] FGRT_OFS_CNT = 4'hc;
	localparam int FGRT_LO = 7;
	localparam int FGRT_HI = 24;
	localparam logic [31:0] FGRT_CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] FGRT_LOR_MASK = 32'h00f8_0000;
	localparam logic [31:0] FGRT_PAUTH_MASK = 32'h0000_0180;
	localparam logic [31:0] FGRT_USER_MASK = 32'h0000_c000;
	localparam logic [31:0] FGRT_FIELD_MASK = 32'h01ff_ff80;
	localparam logic [5:0] FGRT_EC_TRAP = 6'h18;
	localparam int FGRT_CFG_HYP_IMPL = 0;
	localparam int FGRT_CFG_HYP_EN = 1;
	localparam int FGRT_CFG_MON_IMPL = 2;
	localparam int FGRT_CFG_MON_FGT = 3;
	localparam int FGRT_CFG_HOST_EXT = 4;
	localparam int FGRT_CFG_GEN_TRAP = 5;
	localparam logic [5:0] FGRT_CFG_RST = 6'h00;
	localparam logic [1:0] FGRT_LVL_USER = 2'h0;
	localparam logic [1:0] FGRT_LVL_KERNEL = 2'h1;
	localparam logic [1:0] FGRT_RESP_OKAY = 2'h0;
	localparam logic [1:0] FGRT_RESP_SLVERR = 2'h2;
endpackage : fgrt_pkg

//--- src/fgrt_top.sv
// Fine-grain read trap: holds trap fields 24..7 and judges each
// system register read request from the core.
// Assumes the core presents one read per cycle on its own clock, and that
// reg_sel is the field bit index of the register being read.
`timescale 1ns/100ps
`default_nettype none
module fgrt_top #(
	parameter bit HAS_LOR = 1'b1,
	parameter bit HAS_PAUTH = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [3:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [3:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic rd_valid,
	input wire logic [4:0] reg_sel,
	input wire logic [1:0] cur_level,
	input wire logic wide_state,
	output logic trap_valid,
	output logic [5:0] trap_class,
	output logic pass_valid
);
	logic [31:0] ctrl_reg;
	logic [5:0] cfg_reg;
	logic [31:0] impl_mask;
	logic [3:0] aw_addr_reg;
	logic aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic w_have_reg;
	logic [31:0] trap_cnt_reg;
	logic last_trap_reg;
	logic gate_ok;
	logic field_hit;
	logic trap_next;
	logic host_pair;
	logic [31:0] field_armed;

	// Fields whose feature is absent stay zero and cannot be written
	assign impl_mask = fgrt_pkg::FGRT_FIELD_MASK
		& ~(HAS_LOR ? 32'h0 : fgrt_pkg::FGRT_LOR_MASK)
		& ~(HAS_PAUTH ? 32'h0 : fgrt_pkg::FGRT_PAUTH_MASK);

	function automatic logic [31:0] fgrt_merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] st);
		logic [31:0] res;
		res = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				res[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
		return res;
	endfunction : fgrt_merge

	// Dual fields are also reachable from the user level
	function automatic logic fgrt_dual(input logic [4:0] sel);
		return fgrt_pkg::FGRT_USER_MASK[sel];
	endfunction : fgrt_dual

	// Write channel: address and data taken in either order
	wire do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 4'h0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_have_reg <= 1'b1;
			aw_addr_reg <= s_axi_awaddr;
		end else if (do_write) begin
			aw_have_reg <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			w_have_reg <= 1'b0;
			w_data_reg <= 32'h0;
			w_strb_reg <= 4'h0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_have_reg <= 1'b1;
			w_data_reg <= s_axi_wdata;
			w_strb_reg <= s_axi_wstrb;
		end else if (do_write) begin
			w_have_reg <= 1'b0;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready)
				&& !s_axi_bvalid;
			s_axi_wready <= !w_have_reg && !(s_axi_wvalid && s_axi_wready)
				&& !s_axi_bvalid;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= fgrt_pkg::FGRT_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_addr_reg == fgrt_pkg::FGRT_OFS_CTRL
				|| aw_addr_reg == fgrt_pkg::FGRT_OFS_CFG)
				? fgrt_pkg::FGRT_RESP_OKAY : fgrt_pkg::FGRT_RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Trap field register; warm reset is rst
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= fgrt_pkg::FGRT_CTRL_RST;
		end else if (do_write && aw_addr_reg == fgrt_pkg::FGRT_OFS_CTRL) begin
			ctrl_reg <= fgrt_merge(ctrl_reg, w_data_reg, w_strb_reg)
				& impl_mask;
		end
	end
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			cfg_reg <= fgrt_pkg::FGRT_CFG_RST;
		end else if (do_write && aw_addr_reg == fgrt_pkg::FGRT_OFS_CFG
			&& w_strb_reg[0]) begin
			cfg_reg <= w_data_reg[5:0];
		end
	end

	// Read channel
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= fgrt_pkg::FGRT_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= fgrt_pkg::FGRT_RESP_OKAY;
			unique case (s_axi_araddr)
				fgrt_pkg::FGRT_OFS_CTRL: s_axi_rdata <= ctrl_reg;
				fgrt_pkg::FGRT_OFS_CFG: s_axi_rdata <= {26'h0, cfg_reg};
				fgrt_pkg::FGRT_OFS_STAT: s_axi_rdata <= {31'h0, last_trap_reg};
				fgrt_pkg::FGRT_OFS_CNT: s_axi_rdata <= trap_cnt_reg;
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= fgrt_pkg::FGRT_RESP_SLVERR;
				end
			endcase
		end else begin
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
			s_axi_arready <= !s_axi_rvalid || s_axi_rready;
		end
	end

	// Common enabling condition
	assign gate_ok = cfg_reg[fgrt_pkg::FGRT_CFG_HYP_IMPL]
		&& cfg_reg[fgrt_pkg::FGRT_CFG_HYP_EN]
		&& (!cfg_reg[fgrt_pkg::FGRT_CFG_MON_IMPL]
		|| cfg_reg[fgrt_pkg::FGRT_CFG_MON_FGT]);

	assign host_pair = cfg_reg[fgrt_pkg::FGRT_CFG_HOST_EXT]
		&& cfg_reg[fgrt_pkg::FGRT_CFG_GEN_TRAP];

	// One arming bit per field; indices outside the range never divert
	for (genvar gi = 0; gi < 32; gi++) begin : g_field
		if (gi >= fgrt_pkg::FGRT_LO && gi <= fgrt_pkg::FGRT_HI) begin : g_live
			assign field_armed[gi] = ctrl_reg[gi];
			a_field_trap: assert property (@(posedge sys_clk)
				disable iff (rst)
				(rd_valid && reg_sel == 5'(gi) && ctrl_reg[gi]
				&& gate_ok && wide_state
				&& cur_level == fgrt_pkg::FGRT_LVL_KERNEL
				&& !(fgrt_dual(5'(gi)) && host_pair))
				|=> trap_valid)
				else $error("field read not diverted");
		end else begin : g_dead
			assign field_armed[gi] = 1'b0;
		end
	end

	// Field lookup; a zero field never diverts
	assign field_hit = field_armed[reg_sel];

	// Kernel reads for all fields; user reads only for the two dual fields
	always_comb begin
		trap_next = 1'b0;
		if (rd_valid && wide_state && gate_ok && field_hit) begin
			unique case (cur_level)
				fgrt_pkg::FGRT_LVL_KERNEL: begin
					// Dual fields also need the host pair clear
					trap_next = !(fgrt_dual(reg_sel)
						&& host_pair);
				end
				fgrt_pkg::FGRT_LVL_USER: begin
					trap_next = fgrt_dual(reg_sel) && !host_pair;
				end
				default: begin
					trap_next = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trap_valid <= 1'b0;
			pass_valid <= 1'b0;
			trap_class <= 6'h00;
			last_trap_reg <= 1'b0;
		end else begin
			trap_valid <= trap_next;
			pass_valid <= rd_valid && !trap_next;
			trap_class <= trap_next ? fgrt_pkg::FGRT_EC_TRAP : 6'h00;
			if (rd_valid) begin
				last_trap_reg <= trap_next;
			end
		end
	end
	// Count saturates rather than wrapping so software never sees a reset
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			trap_cnt_reg <= 32'h0;
		end else if (trap_next && trap_cnt_reg != 32'hffff_ffff) begin
			trap_cnt_reg <= trap_cnt_reg + 32'h1;
		end
	end

	// Decision checks
	a_gate_blocks: assert property (@(posedge sys_clk)
		disable iff (rst)
		!gate_ok |=> !trap_valid)
		else $error("trap without gate");

	a_zero_field: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && !field_hit) |=> !trap_valid && pass_valid)
		else $error("zero field diverted");

	a_trap_class: assert property (@(posedge sys_clk)
		disable iff (rst)
		trap_valid |-> trap_class == fgrt_pkg::FGRT_EC_TRAP)
		else $error("bad class");

	a_class_idle: assert property (@(posedge sys_clk)
		disable iff (rst)
		!trap_valid |-> trap_class == 6'h00)
		else $error("class without trap");

	// A dual field under the host pair is not diverted even from kernel
	a_kernel_trap: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && wide_state && gate_ok && field_hit
		&& cur_level == fgrt_pkg::FGRT_LVL_KERNEL
		&& !(fgrt_dual(reg_sel) && host_pair)) |=> trap_valid)
		else $error("missed trap");

	a_user_host: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && cur_level == fgrt_pkg::FGRT_LVL_USER && host_pair)
		|=> !trap_valid)
		else $error("user trap under host");

	a_user_dual: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && wide_state && gate_ok && field_hit && !host_pair
		&& cur_level == fgrt_pkg::FGRT_LVL_USER && fgrt_dual(reg_sel))
		|=> trap_valid)
		else $error("user dual read not diverted");

	a_user_plain: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && cur_level == fgrt_pkg::FGRT_LVL_USER
		&& !fgrt_dual(reg_sel)) |=> !trap_valid)
		else $error("user trap on kernel field");

	a_high_level: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && cur_level[1]) |=> !trap_valid)
		else $error("trap at upper level");

	a_narrow_state: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && !wide_state) |=> !trap_valid)
		else $error("trap in narrow state");

	a_out_range: assert property (@(posedge sys_clk)
		disable iff (rst)
		(rd_valid && (reg_sel < 5'(fgrt_pkg::FGRT_LO)
		|| reg_sel > 5'(fgrt_pkg::FGRT_HI))) |=> !trap_valid)
		else $error("trap outside field range");

	a_answer_once: assert property (@(posedge sys_clk)
		disable iff (rst)
		rd_valid |=> (trap_valid || pass_valid))
		else $error("read left unanswered");

	a_no_answer: assert property (@(posedge sys_clk)
		disable iff (rst)
		!rd_valid |=> (!trap_valid && !pass_valid))
		else $error("answer without read");

	a_one_answer: assert property (@(posedge sys_clk)
		disable iff (rst)
		!(trap_valid && pass_valid))
		else $error("both answers");

	a_status_track: assert property (@(posedge sys_clk)
		disable iff (rst)
		rd_valid |=> last_trap_reg == trap_valid)
		else $error("status not following decision");

	// Feature and reset checks
	a_lor_absent: assert property (@(posedge sys_clk)
		disable iff (rst)
		!HAS_LOR |-> (ctrl_reg & fgrt_pkg::FGRT_LOR_MASK) == 32'h0)
		else $error("lor field set");

	a_lor_trap: assert property (@(posedge sys_clk)
		disable iff (rst)
		(!HAS_LOR && rd_valid && fgrt_pkg::FGRT_LOR_MASK[reg_sel])
		|=> !trap_valid)
		else $error("absent lor field diverted");

	a_pauth_absent: assert property (@(posedge sys_clk)
		disable iff (rst)
		!HAS_PAUTH |-> (ctrl_reg & fgrt_pkg::FGRT_PAUTH_MASK) == 32'h0)
		else $error("key field set");

	a_pauth_trap: assert property (@(posedge sys_clk)
		disable iff (rst)
		(!HAS_PAUTH && rd_valid && fgrt_pkg::FGRT_PAUTH_MASK[reg_sel])
		|=> !trap_valid)
		else $error("absent key field diverted");

	a_ctrl_mask: assert property (@(posedge sys_clk)
		disable iff (rst)
		(ctrl_reg & ~impl_mask) == 32'h0)
		else $error("unimplemented field set");

	a_reset_clear: assert property (@(posedge sys_clk)
		$fell(rst) |-> ctrl_reg == fgrt_pkg::FGRT_CTRL_RST)
		else $error("fields not cleared");

	a_cfg_clear: assert property (@(posedge sys_clk)
		$fell(rst) |-> cfg_reg == fgrt_pkg::FGRT_CFG_RST)
		else $error("config not cleared");

	// Bus checks: responses stand until taken, no new write accepted meanwhile
	a_bvalid_hold: assert property (@(posedge sys_clk)
		disable iff (rst)
		(s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid)
		else $error("write response dropped");

	a_rvalid_hold: assert property (@(posedge sys_clk)
		disable iff (rst)
		(s_axi_rvalid && !s_axi_rready)
		|=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read response dropped");

	a_aw_block: assert property (@(posedge sys_clk)
		disable iff (rst)
		s_axi_bvalid |-> (!s_axi_awready && !s_axi_wready))
		else $error("write taken while response pending");

	c_kernel_trap: cover property (@(posedge sys_clk) disable iff (rst)
		trap_valid);
	c_pass: cover property (@(posedge sys_clk) disable iff (rst)
		pass_valid);
	c_user_trap: cover property (@(posedge sys_clk) disable iff (rst)
		rd_valid && cur_level == 2'h0 ##1 trap_valid);
	c_host_block: cover property (@(posedge sys_clk) disable iff (rst)
		rd_valid && field_hit && host_pair ##1 pass_valid);
	c_write_done: cover property (@(posedge sys_clk) disable iff (rst)
		s_axi_bvalid && s_axi_bready);
endmodule : fgrt_top
`default_nettype wire

//--- dv/fgrt_tb.sv
// Testbench for the fine-grain read trap block: registers over AXI4-Lite,
// per-cycle trap decisions on the core read port.
// Assumes fgrt_pkg and fgrt_top are compiled first.
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] awaddr = 4'h0, araddr = 4'h0;
	logic [31:0] wdata = 32'h0, rdata, rdata2, d, d2, ctrl_v;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic arvalid = 1'b0, rready = 1'b0, rd_valid = 1'b0, wide_state = 1'b0;
	logic [4:0] reg_sel = 5'h00;
	logic [1:0] cur_level = 2'h0, bresp, rresp;
	logic [5:0] trap_class, cfg_v;
	logic awready, wready, bvalid, arready, rvalid, trap_valid, pass_valid;
	logic trap2, pv = 1'b0, pt = 1'b0, pt2 = 1'b0;
	int errors = 0;
	int check_count = 0;
	// Features off in the second copy, so absent fields must stay inert
	localparam logic [31:0] NOFEAT = ~(fgrt_pkg::FGRT_LOR_MASK |
		fgrt_pkg::FGRT_PAUTH_MASK);
	always #4 sys_clk = ~sys_clk;
	fgrt_top uut (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rd_valid(rd_valid), .reg_sel(reg_sel),
		.cur_level(cur_level), .wide_state(wide_state), .trap_valid(trap_valid),
		.trap_class(trap_class), .pass_valid(pass_valid));
	fgrt_top #(.HAS_LOR(1'b0), .HAS_PAUTH(1'b0)) uut_nofeat (.sys_clk(sys_clk),
		.rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
		.s_axi_wvalid(wvalid), .s_axi_wready(), .s_axi_bresp(),
		.s_axi_bvalid(), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(), .s_axi_rdata(rdata2),
		.s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(rready),
		.rd_valid(rd_valid), .reg_sel(reg_sel), .cur_level(cur_level),
		.wide_state(wide_state), .trap_valid(trap2), .trap_class(),
		.pass_valid());

	task automatic complete_run;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	task automatic check(input string name, input logic [31:0] seen, exp);
		check_count++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] v);
		int n;
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		bready <= 1'b0;
		check("bresp", {30'h0, bresp}, {30'h0, fgrt_pkg::FGRT_RESP_OKAY});
		if (n == 40) begin
			errors++;
			complete_run();
		end
	endtask : axi_wr

	task automatic axi_rd(input logic [3:0] a);
		int n;
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 40; n++) begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		rready <= 1'b0;
		d = rdata;
		d2 = rdata2;
		check("rresp", {30'h0, rresp}, {30'h0, fgrt_pkg::FGRT_RESP_OKAY});
		if (n == 40) begin
			errors++;
			complete_run();
		end
	endtask : axi_rd

	// Expected decision, worked out from the trap conditions alone
	function automatic logic want(input logic [31:0] c, input int s, l,
		input logic w);
		logic lvl_ok;
		lvl_ok = (l == 1) || (l == 0 && (s == 14 || s == 15));
		if ((s == 14 || s == 15) && cfg_v[4] && cfg_v[5]) lvl_ok = 1'b0;
		return c[s] && w && lvl_ok && cfg_v[0] && cfg_v[1] &&
			(!cfg_v[2] || cfg_v[3]);
	endfunction : want

	// Back to back: each call checks the answer to the previous request
	task automatic core_rd(input logic v, input int s, l, input logic w);
		@(posedge sys_clk);
		rd_valid <= v;
		reg_sel <= s[4:0];
		cur_level <= l[1:0];
		wide_state <= w;
		#1;
		check("trap", {31'h0, trap_valid}, {31'h0, pv & pt});
		check("pass", {31'h0, pass_valid}, {31'h0, pv & !pt});
		check("class", {26'h0, trap_class},
			pt ? {26'h0, fgrt_pkg::FGRT_EC_TRAP} : 32'h0);
		check("trap_nofeat", {31'h0, trap2}, {31'h0, pv & pt2});
		pv = v;
		pt = v && want(ctrl_v, s, l, w);
		pt2 = v && want(ctrl_v & NOFEAT, s, l, w);
	endtask : core_rd

	initial begin
		logic [31:0] cl[3] = '{32'h0, 32'hffff_ffff, 32'h0155_5500};
		logic [5:0] gl[8] = '{6'h00, 6'h01, 6'h03, 6'h07, 6'h0f, 6'h33, 6'h3f,
			6'h13};
		ctrl_v = 32'h0;
		cfg_v = 6'h00;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		repeat (2) @(posedge sys_clk);
		for (int k = 0; k < 2; k++) begin
			axi_rd(fgrt_pkg::FGRT_OFS_CTRL);
			check("ctrl_rst", d, 32'h0);
			axi_rd(fgrt_pkg::FGRT_OFS_CFG);
			check("cfg_rst", d, 32'h0);
			if (k == 1) break;
			foreach (cl[i]) begin
				axi_wr(fgrt_pkg::FGRT_OFS_CTRL, cl[i]);
				ctrl_v = cl[i] & fgrt_pkg::FGRT_FIELD_MASK;
				axi_rd(fgrt_pkg::FGRT_OFS_CTRL);
				check("ctrl", d, ctrl_v);
				check("ctrl_nofeat", d2, ctrl_v & NOFEAT);
				foreach (gl[j]) begin
					axi_wr(fgrt_pkg::FGRT_OFS_CFG, {26'h0, gl[j]});
					cfg_v = gl[j];
					for (int s = 0; s < 32; s++)
						for (int l = 0; l < 4; l++)
							for (int w = 0; w < 2; w++)
								core_rd(1'b1, s, l, w[0]);
					core_rd(1'b0, 0, 0, 1'b0);
				end
			end
			// Warm reset in mid-run must clear every field again
			rst <= 1'b1;
			repeat (3) @(posedge sys_clk);
			rst <= 1'b0;
			ctrl_v = 32'h0;
			cfg_v = 6'h00;
			repeat (2) @(posedge sys_clk);
		end
		axi_wr(fgrt_pkg::FGRT_OFS_CTRL, 32'h0001_0000);
		axi_wr(fgrt_pkg::FGRT_OFS_CFG, 32'h3);
		ctrl_v = 32'h0001_0000;
		cfg_v = 6'h03;
		repeat (3) core_rd(1'b1, 16, 1, 1'b1);
		core_rd(1'b1, 17, 1, 1'b1);
		core_rd(1'b0, 0, 0, 1'b0);
		axi_rd(fgrt_pkg::FGRT_OFS_STAT);
		check("status", d & 32'h1, 32'h0);
		axi_rd(fgrt_pkg::FGRT_OFS_CNT);
		check("count", d, 32'h3);
		complete_run();
	end
endmodule : testbench
`default_nettype wire
